// >>> rtl/urts_defs.svh
/*
 holds register offsets, field positions, reset values and timing counts of the
 receive-timeout and flag block. assumes inclusion by bare name.
*/
`ifndef URTS_DEFS_SVH
`define URTS_DEFS_SVH
`define URTS_OFF_TIMEOUT 12'h00c
`define URTS_OFF_FLAGS 12'h018
`define URTS_OFF_CTRL 12'h030
`define URTS_OFF_IRQ_STAT 12'h034
`define URTS_OFF_IRQ_EN 12'h038
`define URTS_OFF_IRQ_CLR 12'h03c
`define URTS_TIMEOUT_RST 22'h0001ff
`define URTS_TIMEOUT_W 22
`define URTS_FB_CTS 0
`define URTS_FB_BUSY 3
`define URTS_FB_RX_EMPTY_FLAG 4
`define URTS_FB_TX_FULL_FLAG 5
`define URTS_FB_RX_FULL_FLAG 6
`define URTS_FB_TX_EMPTY_FLAG 7
`define URTS_FB_CTS_CHANGE_FLAG 9
`define URTS_FB_RSV_LO 10
`define URTS_FB_RSV_HI 12
`define URTS_FB_REMOTE_TX_PAUSED 13
`define URTS_FR_RSV_VAL 3'h7
`define URTS_CB_UART_EN 0
`define URTS_CB_TX_EN 1
`define URTS_CB_OVS 2
`define URTS_CB_FIFO_EN 3
`define URTS_CB_SWFC 4
`define URTS_CTRL_W 5
`define URTS_OVS16 5'h10
`define URTS_OVS8 5'h08
`define URTS_XOFF 8'h13
`define URTS_XON 8'h11
`endif

// >>> rtl/urts_pkg.sv
/*
 holds the types of the receive-timeout and flag block.
 assumes the defs header is compiled alongside.
*/
`default_nettype none
package urts_pkg;
   typedef enum logic [1:0] {
      URTS_TX_IDLE = 2'b00,
      URTS_TX_SHIFT = 2'b01,
      URTS_TX_STOP = 2'b11
   } urts_tx_state_t;
endpackage
`default_nettype wire

// >>> rtl/urts_sync.sv
/*
 holds a two-flop synchroniser for a level from outside the clock domain.
 assumes pclk and async active-low reset.
*/
`default_nettype none
module urts_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic d,
   output logic q
);
   logic meta_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= 1'b0;
         q <= 1'b0;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/urts_fifo_mem.sv
/*
 holds a small register-file memory with registered read data.
 assumes one write and one read port on pclk, no reset of the contents.
*/
`default_nettype none
module urts_fifo_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic pclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
   always_ff @(posedge pclk) begin
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// >>> rtl/urts_top.sv
/*
 holds the receive-timeout interrupt, flag register, a small transmit path and
 apb slave of the serial port. assumes received characters and fifo pops come
 from the surrounding receiver on pclk; only the cts pin is asynchronous.
*/
// Register access over APB was chosen for this implementation.
//  Function
// - timeout irq when rx data idle too long
// - timeout is period oversample ticks
// - 22-bit period field, resets to 0x1ff
// - busy high until last stop bit sent
// - tx disable clears busy once tx fifo empty, re-enable resumes
// - busy set once tx fifo non-empty
// - rx empty flag per mode, resets 1
// - tx full flag per mode
// - rx full flag per mode
// - tx empty flag per mode, resets 1
// - cts change flag since last read, resets 1
// - paused flag set after xoff sent
// - paused flag cleared after xon sent
// - oversample select picks 16 or 8
// - fifo disabled means single holding register
`include "urts_defs.svh"
`default_nettype none
module urts_top
   import urts_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW = 4,
   parameter logic [15:0] BAUD_DIV = 16'h0001,
   parameter logic [AW:0] RX_TRIG = 5'd8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cts_n,
   output logic txd,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char,
   input wire logic rx_pop,
   output logic [7:0] rx_data,
   input wire logic tx_push,
   input wire logic [7:0] tx_char,
   output logic irq
);
   logic [`URTS_TIMEOUT_W-1:0] period_ff;
   logic [`URTS_CTRL_W-1:0] ctrl_ff;
   logic [1:0] irq_stat_ff, irq_en_ff;
   logic [AW:0] rx_cnt_ff, tx_cnt_ff;
   logic [AW-1:0] rx_wp_ff, rx_rp_ff, tx_wp_ff, tx_rp_ff;
   logic [21:0] to_cnt_ff;
   logic [15:0] baud_cnt_ff;
   logic [4:0] ovs_cnt_ff;
   logic cts_s, cts_last_ff, cts_change_flag_ff, paused_ff, busy_ff;
   logic cts_n_s;
   logic [3:0] bit_cnt_ff;
   logic [9:0] shift_ff;
   logic [7:0] tx_mem_q, rx_mem_q;
   urts_tx_state_t tx_st_ff;
   logic tick, bit_tick, acc, wr, rd, rx_take, tx_take, tx_load, fifo_en;
   logic send_xoff, send_xon, ctrl_pend_ff, ctrl_is_xoff_ff;
   logic rx_empty, rx_full, tx_empty, tx_full;
   logic [AW:0] cap;
   logic [4:0] ovs;
   logic [31:0] flags;

   function automatic logic [AW:0] depth_cap(input logic en);
      return en ? (AW+1)'(DEPTH) : (AW+1)'(1);
   endfunction

   // the raw pin goes straight into the flops; its reset level 0 means clear-to-send
   urts_sync u_cts (.pclk(pclk), .presetn(presetn), .d(cts_n), .q(cts_n_s));
   assign cts_s = !cts_n_s;

   urts_fifo_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_rxm (
      .pclk(pclk), .we(rx_take), .waddr(rx_wp_ff), .wdata(rx_char),
      .raddr(rx_rp_ff), .rdata(rx_mem_q));
   urts_fifo_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) u_txm (
      .pclk(pclk), .we(tx_take), .waddr(tx_wp_ff), .wdata(tx_char),
      .raddr(tx_rp_ff), .rdata(tx_mem_q));

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign fifo_en = ctrl_ff[`URTS_CB_FIFO_EN];
   assign cap = depth_cap(fifo_en);
   assign rx_empty = (rx_cnt_ff == '0);
   assign rx_full = (rx_cnt_ff >= cap);
   assign tx_empty = (tx_cnt_ff == '0);
   assign tx_full = (tx_cnt_ff >= cap);
   assign rx_take = rx_char_valid && !rx_full;
   assign tx_take = tx_push && !tx_full;
   assign ovs = ctrl_ff[`URTS_CB_OVS] ? `URTS_OVS8 : `URTS_OVS16;
   assign send_xoff = ctrl_ff[`URTS_CB_SWFC] && !paused_ff && (rx_cnt_ff > RX_TRIG);
   assign send_xon = ctrl_ff[`URTS_CB_SWFC] && paused_ff && (rx_cnt_ff <= RX_TRIG);
   assign tx_load = (tx_st_ff == URTS_TX_IDLE) && ctrl_ff[`URTS_CB_UART_EN]
      && ctrl_ff[`URTS_CB_TX_EN] && cts_s && bit_tick && (ctrl_pend_ff || !tx_empty);

   always_comb begin
      flags = 32'h0000_0000;
      flags[`URTS_FB_CTS] = cts_s;
      flags[`URTS_FB_BUSY] = busy_ff;
      flags[`URTS_FB_RX_EMPTY_FLAG] = rx_empty;
      flags[`URTS_FB_TX_FULL_FLAG] = tx_full;
      flags[`URTS_FB_RX_FULL_FLAG] = rx_full;
      flags[`URTS_FB_TX_EMPTY_FLAG] = tx_empty;
      flags[`URTS_FB_CTS_CHANGE_FLAG] = cts_change_flag_ff;
      flags[`URTS_FB_RSV_HI:`URTS_FB_RSV_LO] = `URTS_FR_RSV_VAL;
      flags[`URTS_FB_REMOTE_TX_PAUSED] = paused_ff;
   end

   // one-cycle access phase: pready is a flop that rises in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `URTS_OFF_TIMEOUT: prdata <= {10'h000, period_ff};
               `URTS_OFF_FLAGS: prdata <= flags;
               `URTS_OFF_CTRL: prdata <= {27'h0, ctrl_ff};
               `URTS_OFF_IRQ_STAT: prdata <= {30'h0, irq_stat_ff};
               `URTS_OFF_IRQ_EN: prdata <= {30'h0, irq_en_ff};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_ff <= `URTS_TIMEOUT_RST;
         ctrl_ff <= '0;
         irq_en_ff <= 2'b00;
      end else if (wr) begin
         if (paddr == `URTS_OFF_TIMEOUT) period_ff <= pwdata[21:0];
         if (paddr == `URTS_OFF_CTRL) ctrl_ff <= pwdata[`URTS_CTRL_W-1:0];
         if (paddr == `URTS_OFF_IRQ_EN) irq_en_ff <= pwdata[1:0];
      end
   end

   // bit-time ticks: ovs oversample ticks per bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_cnt_ff <= 16'h0000;
         ovs_cnt_ff <= 5'h00;
      end else if (baud_cnt_ff >= BAUD_DIV - 16'h0001) begin
         baud_cnt_ff <= 16'h0000;
         ovs_cnt_ff <= (ovs_cnt_ff >= ovs - 5'h01) ? 5'h00 : ovs_cnt_ff + 5'h01;
      end else begin
         baud_cnt_ff <= baud_cnt_ff + 16'h0001;
      end
   end
   assign tick = (baud_cnt_ff >= BAUD_DIV - 16'h0001);
   assign bit_tick = tick && (ovs_cnt_ff >= ovs - 5'h01);

   // timeout counts oversample ticks, so period/(ovs*baud) seconds
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         to_cnt_ff <= 22'h000000;
      end else if (rx_take || rx_empty) begin
         to_cnt_ff <= 22'h000000;
      end else if (tick && to_cnt_ff < period_ff) begin
         to_cnt_ff <= to_cnt_ff + 22'h000001;
      end
   end

   // bit0 timeout, bit1 cts change; set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff <= 2'b00;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~((wr && paddr == `URTS_OFF_IRQ_CLR) ? pwdata[1:0] : 2'b00))
            | {cts_s != cts_last_ff,
               !rx_empty && tick && (to_cnt_ff == period_ff - 22'h000001)};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_ff & irq_en_ff);
      end
   end

   // change seen on a read cycle stays set for the next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // matches the synchroniser's reset level, so release shows no false change
         cts_last_ff <= 1'b1;
         cts_change_flag_ff <= 1'b1;
      end else begin
         cts_last_ff <= cts_s;
         if (cts_s != cts_last_ff) begin
            cts_change_flag_ff <= 1'b1;
         end else if (rd && paddr == `URTS_OFF_FLAGS) begin
            cts_change_flag_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_cnt_ff <= '0;
         rx_wp_ff <= '0;
         rx_rp_ff <= '0;
      end else begin
         if (rx_take) rx_wp_ff <= fifo_en ? rx_wp_ff + AW'(1) : '0;
         if (rx_pop && !rx_empty) rx_rp_ff <= fifo_en ? rx_rp_ff + AW'(1) : '0;
         rx_cnt_ff <= rx_cnt_ff + (AW+1)'(rx_take) - (AW+1)'(rx_pop && !rx_empty);
      end
   end
   assign rx_data = rx_mem_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_cnt_ff <= '0;
         tx_wp_ff <= '0;
         tx_rp_ff <= '0;
      end else begin
         if (tx_take) tx_wp_ff <= fifo_en ? tx_wp_ff + AW'(1) : '0;
         if (tx_load && !ctrl_pend_ff) tx_rp_ff <= fifo_en ? tx_rp_ff + AW'(1) : '0;
         tx_cnt_ff <= tx_cnt_ff + (AW+1)'(tx_take) - (AW+1)'(tx_load && !ctrl_pend_ff);
      end
   end

   // flow-control characters go ahead of queued data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_pend_ff <= 1'b0;
         ctrl_is_xoff_ff <= 1'b0;
         paused_ff <= 1'b0;
      end else begin
         if (!ctrl_pend_ff && (send_xoff || send_xon)) begin
            ctrl_pend_ff <= 1'b1;
            ctrl_is_xoff_ff <= send_xoff;
         end else if (tx_load && ctrl_pend_ff) begin
            ctrl_pend_ff <= 1'b0;
         end
         if (tx_st_ff == URTS_TX_STOP && bit_tick && shift_ff[9:2] == `URTS_XOFF) begin
            paused_ff <= 1'b1;
         end else if (tx_st_ff == URTS_TX_STOP && bit_tick && shift_ff[9:2] == `URTS_XON) begin
            paused_ff <= 1'b0;
         end
      end
   end

   // shift_ff keeps the character so the stop state still knows it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_ff <= URTS_TX_IDLE;
         shift_ff <= 10'h3ff;
         bit_cnt_ff <= 4'h0;
         txd <= 1'b1;
      end else if (!ctrl_ff[`URTS_CB_TX_EN] || !ctrl_ff[`URTS_CB_UART_EN]) begin
         txd <= 1'b1;
      end else if (bit_tick) begin
         unique case (tx_st_ff)
            URTS_TX_IDLE: begin
               if (tx_load) begin
                  shift_ff <= {ctrl_pend_ff ? (ctrl_is_xoff_ff ? `URTS_XOFF : `URTS_XON)
                     : tx_mem_q, 2'b01};
                  bit_cnt_ff <= 4'h0;
                  txd <= 1'b0;
                  tx_st_ff <= URTS_TX_SHIFT;
               end
            end
            URTS_TX_SHIFT: begin
               txd <= shift_ff[2 + 32'(bit_cnt_ff)];
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
               if (bit_cnt_ff == 4'h7) tx_st_ff <= URTS_TX_STOP;
            end
            URTS_TX_STOP: begin
               txd <= 1'b1;
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
               // a data bit of 1 must not shorten the stop bit, so the stop state counts two full bit times
               if (bit_cnt_ff == 4'h9) tx_st_ff <= URTS_TX_IDLE;
            end
            default: tx_st_ff <= URTS_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= !tx_empty
            || ((tx_st_ff != URTS_TX_IDLE) && ctrl_ff[`URTS_CB_TX_EN]
                && ctrl_ff[`URTS_CB_UART_EN]);
      end
   end

   a_busy_fifo: assert property (@(posedge pclk) disable iff (!presetn)
      !tx_empty |=> busy_ff) else $error("busy low with tx data");
   a_rx_empty_flag_flag: assert property (@(posedge pclk) disable iff (!presetn)
      flags[`URTS_FB_RX_EMPTY_FLAG] == (rx_cnt_ff == '0)) else $error("rx empty wrong");
   a_tx_full_flag_flag: assert property (@(posedge pclk) disable iff (!presetn)
      !fifo_en && tx_cnt_ff != '0 |-> flags[`URTS_FB_TX_FULL_FLAG]) else $error("tx full wrong");
   a_rx_full_flag_flag: assert property (@(posedge pclk) disable iff (!presetn)
      fifo_en && rx_cnt_ff < DEPTH |-> !flags[`URTS_FB_RX_FULL_FLAG]) else $error("rx full wrong");
   a_tx_empty_flag_flag: assert property (@(posedge pclk) disable iff (!presetn)
      tx_take && tx_empty |=> !flags[`URTS_FB_TX_EMPTY_FLAG]) else $error("tx empty wrong");
   a_cts_change_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      cts_s != cts_last_ff |=> cts_change_flag_ff) else $error("cts change lost");
   a_cts_change_flag_clr: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == `URTS_OFF_FLAGS && cts_s == cts_last_ff |=> !cts_change_flag_ff)
      else $error("cts change not cleared");
   a_to_empty: assert property (@(posedge pclk) disable iff (!presetn)
      rx_empty |=> !irq_stat_ff[0] || $past(irq_stat_ff[0])) else $error("timeout while empty");
   a_busy_dis: assert property (@(posedge pclk) disable iff (!presetn)
      tx_empty && !ctrl_ff[`URTS_CB_TX_EN] ##1 tx_empty |-> !busy_ff)
      else $error("busy while disabled");
   a_paused_set: assert property (@(posedge pclk) disable iff (!presetn)
      tx_st_ff == URTS_TX_STOP && bit_tick && ctrl_ff[1:0] == 2'b11
      && shift_ff[9:2] == `URTS_XOFF |=> paused_ff) else $error("xoff not flagged");
   c_timeout: cover property (@(posedge pclk) disable iff (!presetn) irq_stat_ff[0]);
   c_xoff: cover property (@(posedge pclk) disable iff (!presetn) $rose(paused_ff));
   c_busy: cover property (@(posedge pclk) disable iff (!presetn) $fell(busy_ff));
endmodule
`default_nettype wire

// >>> testbench/urts_remote.sv
/*
 remote serial transceiver model: decodes 8n1 frames seen on txd and drives cts_n.
 assumes the single pclk domain and a fixed bit time counted in clocks.
*/
`default_nettype none
module urts_remote #(
   parameter int BIT_CLKS = 16
) (
   input wire logic pclk,
   input wire logic txd,
   input wire logic hold,
   output logic cts_n,
   output logic [7:0] got,
   output logic [7:0] cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sh;
   // cts is active low, so stalling the sender means driving it high
   assign cts_n = hold;
   initial begin
      got = 8'h00;
      cnt = 8'h00;
      sh = 8'h00;
      forever begin
         @(negedge txd);
         repeat (BIT_CLKS / 2) @(posedge pclk);
         // a glitch shorter than half a bit is not a start bit
         if (txd === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
               repeat (BIT_CLKS) @(posedge pclk);
               sh[i] = txd;
            end
            repeat (BIT_CLKS) @(posedge pclk);
            if (txd === 1'b1) begin
               got = sh;
               cnt = cnt + 8'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
/*
 self-checking bench of the receive-timeout and flag block: apb master,
 receiver-side pulses and a remote transceiver. assumes BAUD_DIV 1, 16 clocks a bit.
*/
`include "urts_defs.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LIMIT = 20000;
   localparam logic [11:0] FLG = `URTS_OFF_FLAGS;
   localparam logic [11:0] TMO = `URTS_OFF_TIMEOUT;
   localparam logic [11:0] CTL = `URTS_OFF_CTRL;
   localparam logic [11:0] IEN = `URTS_OFF_IRQ_EN;
   localparam logic [11:0] ICL = `URTS_OFF_IRQ_CLR;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r, v;
   logic pready, pslverr, cts_n, txd, irq, hold = 1'b0;
   logic rx_char_valid = 1'b0, rx_pop = 1'b0, tx_push = 1'b0;
   logic [7:0] rx_char = 8'h00, tx_char = 8'h00, rx_data, got, cnt, c;
   logic [7:0] q[$];
   int num_errors = 0, compares = 0, cyc = 0, n;
   always #20 pclk = ~pclk;
   urts_top #(.DEPTH(16), .AW(4), .BAUD_DIV(16'h0001), .RX_TRIG(5'd8)) i_urts_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cts_n(cts_n), .txd(txd), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .rx_pop(rx_pop), .rx_data(rx_data), .tx_push(tx_push), .tx_char(tx_char), .irq(irq));
   urts_remote #(.BIT_CLKS(16)) i_urts_remote (.pclk(pclk), .txd(txd), .hold(hold),
      .cts_n(cts_n), .got(got), .cnt(cnt));
   task automatic end_of_test();
      if (num_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] to_exp(input logic [31:0] w);
      return w & 32'h003fffff;
   endfunction
   function automatic logic [7:0] rc();
      return 8'h20 + 8'($urandom % 96);
   endfunction
   // waits on pready with no count of its own: the watchdog ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(r & m, e);
   endtask
   task automatic pulse(input int k, input logic [7:0] ch);
      rx_char_valid <= (k == 0);
      rx_pop <= (k == 1);
      tx_push <= (k == 2);
      rx_char <= ch;
      tx_char <= ch;
      @(posedge pclk);
      {rx_char_valid, rx_pop, tx_push} <= 3'b000;
      @(posedge pclk);
   endtask
   task automatic wait_got(input logic [7:0] e);
      while (got !== e) @(posedge pclk);
      chk(got, e);
   endtask
   initial begin
      void'($urandom(32'h69143c97));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(FLG, 32'hffffffff, 32'h00001e91);
      rd(FLG, 32'hffffffff, 32'h00001c91);
      rd(TMO, 32'hffffffff, 32'h000001ff);
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 32'hffffffff : $urandom;
         apb(1'b1, TMO, v);
         rd(TMO, 32'hffffffff, to_exp(v));
      end
      apb(1'b1, 12'h100, 32'hffffffff);
      rd(12'h100, 32'hffffffff, 32'h0);
      apb(1'b1, IEN, 32'h2);
      hold <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(irq, 1'b1);
      rd(`URTS_OFF_IRQ_STAT, 32'h2, 32'h2);
      rd(FLG, 32'h201, 32'h200);
      rd(FLG, 32'h201, 32'h000);
      hold <= 1'b0;
      repeat (8) @(posedge pclk);
      rd(FLG, 32'h201, 32'h201);
      apb(1'b1, ICL, 32'h2);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, CTL, 32'h8);
      for (int i = 0; i < 17; i++) begin
         c = rc();
         if (i < 16) q.push_back(c);
         pulse(0, c);
      end
      rd(FLG, 32'h50, 32'h40);
      while (q.size() > 0) begin
         repeat (2) @(posedge pclk);
         chk(rx_data, q.pop_front());
         pulse(1, 8'h00);
      end
      rd(FLG, 32'h50, 32'h10);
      apb(1'b1, CTL, 32'h0);
      pulse(0, rc());
      rd(FLG, 32'h50, 32'h40);
      pulse(1, 8'h00);
      rd(FLG, 32'h50, 32'h10);
      apb(1'b1, TMO, 32'd40);
      apb(1'b1, ICL, 32'h3);
      apb(1'b1, IEN, 32'h1);
      for (int o = 0; o < 2; o++) begin
         apb(1'b1, CTL, 32'h8 + 32'(o * 4));
         pulse(0, rc());
         // second character must restart the idle count
         repeat (30) @(posedge pclk);
         pulse(0, rc());
         n = 0;
         while (irq !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
         end
         chk(n >= 34 && n <= 46, 1'b1);
         pulse(1, 8'h00);
         pulse(1, 8'h00);
         apb(1'b1, ICL, 32'h1);
         repeat (2) @(posedge pclk);
         chk(irq, 1'b0);
      end
      apb(1'b1, CTL, 32'h8);
      pulse(2, rc());
      rd(FLG, 32'ha8, 32'h08);
      apb(1'b1, CTL, 32'hb);
      repeat (60) @(posedge pclk);
      apb(1'b1, CTL, 32'h8);
      rd(FLG, 32'h8, 32'h0);
      apb(1'b1, CTL, 32'hb);
      rd(FLG, 32'h8, 32'h8);
      repeat (400) @(posedge pclk);
      apb(1'b1, CTL, 32'h8);
      for (int i = 0; i < 16; i++) pulse(2, rc());
      rd(FLG, 32'ha0, 32'h20);
      apb(1'b1, CTL, 32'hb);
      repeat (3000) @(posedge pclk);
      rd(FLG, 32'ha8, 32'h80);
      // top data bit set, so the last data bit before the stop bit is a 1
      c = rc() | 8'h80;
      if (c == got) c = c ^ 8'h01;
      pulse(2, c);
      wait_got(c);
      rd(FLG, 32'h8, 32'h8);
      repeat (20) @(posedge pclk);
      rd(FLG, 32'h8, 32'h0);
      apb(1'b1, CTL, 32'h0);
      pulse(2, rc());
      rd(FLG, 32'h20, 32'h20);
      apb(1'b1, CTL, 32'h3);
      repeat (400) @(posedge pclk);
      apb(1'b1, CTL, 32'h1b);
      for (int i = 0; i < 9; i++) pulse(0, rc());
      wait_got(`URTS_XOFF);
      repeat (20) @(posedge pclk);
      rd(FLG, 32'h2000, 32'h2000);
      pulse(1, 8'h00);
      wait_got(`URTS_XON);
      repeat (20) @(posedge pclk);
      rd(FLG, 32'h2000, 32'h0);
      end_of_test();
   end
endmodule
`default_nettype wire
